// ===== hdl/urs_pkg.sv
package urs_pkg;
    // Register bus shape
    localparam int URS_DATA_W = 16;
    localparam int URS_ADDR_W = 2;
    // Register offsets (word index on the plain port)
    localparam logic [1:0] URS_OFF_STATUS = 2'h0;
    localparam logic [1:0] URS_OFF_DATA = 2'h1;
    localparam logic [1:0] URS_OFF_MODE = 2'h2;
    localparam logic [1:0] URS_OFF_BAUD = 2'h3;
    // Status register field positions
    localparam int URS_BIT_ADDR_EN = 5;
    localparam int URS_BIT_IDLE = 4;
    localparam int URS_BIT_PARITY_FAULT_FLAG = 3;
    localparam int URS_BIT_FRAMING_FAULT_FLAG = 2;
    localparam int URS_BIT_OVR = 1;
    localparam int URS_BIT_AVAIL = 0;
    // Mode register: parity and data selection field at bits 2:1
    localparam int URS_PDS_LSB = 1;
    localparam logic [1:0] URS_PDS_8N = 2'h0;
    localparam logic [1:0] URS_PDS_8E = 2'h1;
    localparam logic [1:0] URS_PDS_8O = 2'h2;
    localparam logic [1:0] URS_PDS_9N = 2'h3;
    // Receive queue and character word {parity err, framing err, data[8:0]}
    localparam int URS_FIFO_DEPTH = 4;
    localparam int URS_CHAR_W = 11;
    localparam int URS_CHAR_PARITY_FAULT_FLAG = 10;
    localparam int URS_CHAR_FRAMING_FAULT_FLAG = 9;
    // Reset values
    localparam logic [1:0] URS_PDS_RST = 2'h0;
    localparam logic [15:0] URS_BAUD_RST = 16'h0363;
    // Receiver states
    typedef enum logic [2:0] {
        URS_S_IDLE = 3'b000,
        URS_S_START = 3'b001,
        URS_S_DATA = 3'b010,
        URS_S_PAR = 3'b011,
        URS_S_STOP = 3'b100
    } urs_state_t;
endpackage

// ===== hdl/urs_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module urs_fifo
    import urs_pkg::*;
#(
    parameter int W = 11,
    parameter int DEPTH = 4
)(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic flush,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [W-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [W-1:0] rd_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
        logic [W-1:0] head;
        logic full;
        logic avail;
    } urs_fifo_t;

    urs_fifo_t s_reg, s_next;
    logic do_wr, do_rd;

    assign wr_ready = ~s_reg.full;
    assign rd_valid = s_reg.avail;
    assign rd_data = s_reg.head;

    // Pointer, count and registered head word
    always_comb
    begin
        s_next = s_reg;
        do_wr = wr_valid && !s_reg.full;
        do_rd = rd_ready && s_reg.avail;
        if (flush)
        begin
            s_next.wr_ptr = '0;
            s_next.rd_ptr = '0;
            s_next.count = '0;
        end
        else
        begin
            if (do_wr)
            begin
                s_next.mem[s_reg.wr_ptr] = wr_data;
                s_next.wr_ptr = (s_reg.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_reg.wr_ptr + 1'b1;
            end
            if (do_rd)
                s_next.rd_ptr = (s_reg.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_reg.rd_ptr + 1'b1;
            if (do_wr && !do_rd)
                s_next.count = s_reg.count + 1'b1;
            else if (do_rd && !do_wr)
                s_next.count = s_reg.count - 1'b1;
        end
        s_next.full = (s_next.count == CW'(DEPTH));
        s_next.avail = (s_next.count != '0);
        s_next.head = s_next.avail ? s_next.mem[s_next.rd_ptr] : '0;
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            s_reg <= '0;
        else if (ce)
            s_reg <= s_next;
    end
endmodule
`default_nettype wire

// ===== hdl/urs_top.sv
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module urs_top
    import urs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic serial_receive_pin,
    input wire logic [URS_ADDR_W-1:0] reg_addr,
    input wire logic [URS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [URS_DATA_W-1:0] reg_rdata
);
    typedef struct packed {
        urs_state_t state;
        logic [15:0] baud_cnt;
        logic [3:0] bit_cnt;
        logic [8:0] receive_shift_register;
        logic par_acc;
        logic par_err;
        logic address_match_enable;
        logic overrun_flag;
        logic [1:0] parity_data_select;
        logic [15:0] baud_div;
        logic [URS_DATA_W-1:0] rdata;
    } urs_top_t;

    urs_top_t s_reg, s_next;

    // Queue handshake, receiver strobes and status decode
    logic q_wr_valid, q_wr_ready, q_rd_valid, q_rd_ready, q_flush;
    logic [URS_CHAR_W-1:0] q_wr_data, q_rd_data;
    logic done, keep, bit_end, half_end, ovr_set, ovr_clr, nine_bit;
    logic [3:0] last_bit;
    logic [URS_DATA_W-1:0] status_word;

    // Read data straight from its register
    assign reg_rdata = s_reg.rdata;

    // Four-entry receive queue with valid/ready on both sides
    urs_fifo #(
        .W(URS_CHAR_W),
        .DEPTH(URS_FIFO_DEPTH)
    ) u_queue (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .flush(q_flush),
        .wr_valid(q_wr_valid),
        .wr_ready(q_wr_ready),
        .wr_data(q_wr_data),
        .rd_valid(q_rd_valid),
        .rd_ready(q_rd_ready),
        .rd_data(q_rd_data)
    );

    // Receiver, queue control and register port
    always_comb
    begin
        s_next = s_reg;
        done = 1'b0;
        bit_end = (s_reg.baud_cnt == s_reg.baud_div);
        half_end = (s_reg.baud_cnt == {1'b0, s_reg.baud_div[15:1]});
        nine_bit = (s_reg.parity_data_select == URS_PDS_9N);
        last_bit = nine_bit ? 4'h8 : 4'h7;
        q_wr_data = '0;
        s_next.baud_cnt = s_reg.baud_cnt + 16'h0001;

        // Bit timing: half period to mid start, then full periods
        case (s_reg.state)
            URS_S_IDLE:
            begin
                s_next.baud_cnt = '0;
                if (!serial_receive_pin)
                    s_next.state = URS_S_START;
            end
            URS_S_START:
            begin
                if (half_end)
                begin
                    s_next.baud_cnt = '0;
                    s_next.bit_cnt = '0;
                    s_next.receive_shift_register = '0;
                    s_next.par_acc = 1'b0;
                    s_next.par_err = 1'b0;
                    // A high level at mid start bit is a glitch
                    s_next.state = serial_receive_pin ? URS_S_IDLE : URS_S_DATA;
                end
            end
            URS_S_DATA:
            begin
                if (bit_end)
                begin
                    s_next.baud_cnt = '0;
                    s_next.receive_shift_register[s_reg.bit_cnt] = serial_receive_pin;
                    s_next.par_acc = s_reg.par_acc ^ serial_receive_pin;
                    s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    if (s_reg.bit_cnt == last_bit)
                    begin
                        if (s_reg.parity_data_select == URS_PDS_8E ||
                            s_reg.parity_data_select == URS_PDS_8O)
                            s_next.state = URS_S_PAR;
                        else
                            s_next.state = URS_S_STOP;
                    end
                end
            end
            URS_S_PAR:
            begin
                if (bit_end)
                begin
                    s_next.baud_cnt = '0;
                    s_next.par_err = (s_reg.par_acc ^ serial_receive_pin) !=
                        (s_reg.parity_data_select == URS_PDS_8O);
                    s_next.state = URS_S_STOP;
                end
            end
            URS_S_STOP:
            begin
                if (bit_end)
                begin
                    done = 1'b1;
                    s_next.state = URS_S_IDLE;
                end
            end
            default:
                s_next.state = URS_S_IDLE;
        endcase

        // Completed character: parity and framing travel with it
        q_wr_data[8:0] = s_reg.receive_shift_register;
        q_wr_data[URS_CHAR_PARITY_FAULT_FLAG] = s_reg.par_err;
        q_wr_data[URS_CHAR_FRAMING_FAULT_FLAG] = !serial_receive_pin;
        keep = !(s_reg.address_match_enable && nine_bit &&
            !s_reg.receive_shift_register[8]);
        // Characters are dropped while overrun stands
        q_wr_valid = done && keep && !s_reg.overrun_flag;
        ovr_set = q_wr_valid && !q_wr_ready;

        // Status word as seen by software
        status_word = '0;
        status_word[URS_BIT_ADDR_EN] = s_reg.address_match_enable;
        status_word[URS_BIT_IDLE] = (s_reg.state == URS_S_IDLE);
        status_word[URS_BIT_PARITY_FAULT_FLAG] = q_rd_valid && q_rd_data[URS_CHAR_PARITY_FAULT_FLAG];
        status_word[URS_BIT_FRAMING_FAULT_FLAG] = q_rd_valid && q_rd_data[URS_CHAR_FRAMING_FAULT_FLAG];
        status_word[URS_BIT_OVR] = s_reg.overrun_flag;
        status_word[URS_BIT_AVAIL] = q_rd_valid;

        // Register writes; overrun can only be cleared, set wins
        ovr_clr = 1'b0;
        if (reg_wr)
        begin
            if (reg_addr == URS_OFF_STATUS)
            begin
                s_next.address_match_enable = reg_wdata[URS_BIT_ADDR_EN];
                ovr_clr = s_reg.overrun_flag && !reg_wdata[URS_BIT_OVR];
            end
            else if (reg_addr == URS_OFF_MODE)
                s_next.parity_data_select = reg_wdata[URS_PDS_LSB +: 2];
            else if (reg_addr == URS_OFF_BAUD)
                s_next.baud_div = reg_wdata;
        end
        if (ovr_set)
            s_next.overrun_flag = 1'b1;
        else if (ovr_clr)
            s_next.overrun_flag = 1'b0;

        // Clearing overrun empties queue and shift register
        q_flush = ovr_clr && !ovr_set;
        if (q_flush)
        begin
            s_next.state = URS_S_IDLE;
            s_next.receive_shift_register = '0;
            s_next.bit_cnt = '0;
            s_next.baud_cnt = '0;
        end

        // Register reads; data read pops the queue head
        q_rd_ready = reg_rd && (reg_addr == URS_OFF_DATA);
        s_next.rdata = '0;
        if (reg_rd)
        begin
            if (reg_addr == URS_OFF_STATUS)
                s_next.rdata = status_word;
            else if (reg_addr == URS_OFF_DATA)
                s_next.rdata = q_rd_valid ? {7'h00, q_rd_data[8:0]} : '0;
            else if (reg_addr == URS_OFF_MODE)
                s_next.rdata = {13'h0000, s_reg.parity_data_select, 1'b0};
            else
                s_next.rdata = s_reg.baud_div;
        end
    end

    // State register with clock enable
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            s_reg <= '0;
            s_reg.state <= URS_S_IDLE;
            s_reg.parity_data_select <= URS_PDS_RST;
            s_reg.baud_div <= URS_BAUD_RST;
        end
        else if (ce)
            s_reg <= s_next;
    end
endmodule
`default_nettype wire

// ===== verif/urs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module urs_chk
    import urs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic serial_receive_pin,
    input wire logic [URS_ADDR_W-1:0] reg_addr,
    input wire logic [URS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [URS_DATA_W-1:0] reg_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst || !ce);
    logic [1:0] pds_reg;
    logic aen_reg, ovr_reg, st_q_reg;
    logic [6:0] hi_reg;
    wire logic st_rd = reg_rd && reg_addr == URS_OFF_STATUS;
    wire logic dt_rd = reg_rd && reg_addr == URS_OFF_DATA;
    // Shadows of mode, address enable, last overrun seen, line high time
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pds_reg <= URS_PDS_RST;
            aen_reg <= 1'b0;
            ovr_reg <= 1'b0;
            st_q_reg <= 1'b0;
            hi_reg <= 7'h00;
        end
        else if (ce)
        begin
            st_q_reg <= st_rd;
            hi_reg <= !serial_receive_pin ? 7'h00 : hi_reg + 7'(hi_reg != 7'h7F);
            if (reg_wr && reg_addr == URS_OFF_MODE)
                pds_reg <= reg_wdata[URS_PDS_LSB +: 2];
            if (reg_wr && reg_addr == URS_OFF_STATUS)
            begin
                aen_reg <= reg_wdata[URS_BIT_ADDR_EN];
                if (!reg_wdata[URS_BIT_OVR])
                    ovr_reg <= 1'b0;
            end
            else if (st_q_reg)
                ovr_reg <= reg_rdata[URS_BIT_OVR];
        end
    end
    sequence s_clr;
        reg_wr && reg_addr == URS_OFF_STATUS && !reg_wdata[URS_BIT_OVR] && ovr_reg;
    endsequence
    sequence s_start;
        $fell(serial_receive_pin) ##2 st_rd;
    endsequence
    property p_quiet;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_quiet: assert property (p_quiet) else $error("read data not zero after idle cycle");
    property p_idle;
        st_rd && hi_reg >= 7'h40 |=> reg_rdata[URS_BIT_IDLE];
    endproperty
    a_idle: assert property (p_idle) else $error("idle flag low on quiet line");
    property p_busy;
        s_start |=> !reg_rdata[URS_BIT_IDLE];
    endproperty
    a_busy: assert property (p_busy) else $error("idle flag high in start bit");
    property p_empty;
        st_rd ##1 !reg_rdata[URS_BIT_AVAIL] |-> reg_rdata[URS_BIT_PARITY_FAULT_FLAG:URS_BIT_FRAMING_FAULT_FLAG] == 2'b00;
    endproperty
    a_empty: assert property (p_empty) else $error("fault flag with empty queue");
    property p_nopar;
        st_rd && (pds_reg == URS_PDS_8N || pds_reg == URS_PDS_9N) |=> !reg_rdata[URS_BIT_PARITY_FAULT_FLAG];
    endproperty
    a_nopar: assert property (p_nopar) else $error("parity fault without parity");
    property p_bit8;
        dt_rd && pds_reg != URS_PDS_9N |=> !reg_rdata[8];
    endproperty
    a_bit8: assert property (p_bit8) else $error("ninth bit in 8-bit format");
    property p_addr;
        dt_rd && pds_reg == URS_PDS_9N && aen_reg ##1 reg_rdata != 16'h0000 |-> reg_rdata[8];
    endproperty
    a_addr: assert property (p_addr) else $error("non-address char stored");
    property p_flush;
        s_clr ##[1:2] st_rd |=> reg_rdata[URS_BIT_OVR:URS_BIT_AVAIL] == 2'b00;
    endproperty
    a_flush: assert property (p_flush) else $error("queue not emptied by clear");
endmodule
bind urs_top urs_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
    .serial_receive_pin(serial_receive_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// ===== verif/urs_tx_model.sv
`timescale 1ns/10ps
`default_nettype none
module urs_tx_model
    import urs_pkg::*;
#(
    parameter int BIT_CLKS = 4
)(
    input wire logic sys_clk,
    output logic serial_receive_pin
);
    initial serial_receive_pin = 1'b1;
    // One bit held for a whole bit period
    task automatic put(input logic b);
        @(posedge sys_clk);
        serial_receive_pin <= b;
        repeat (BIT_CLKS - 1) @(posedge sys_clk);
    endtask
    // Start, data LSB first, parity if selected, stop, idle bit
    task automatic send(input logic [8:0] d, input logic [1:0] pds, input logic bp, input logic bs);
        put(1'b0);
        for (int i = 0; i < (pds == URS_PDS_9N ? 9 : 8); i++)
            put(d[i]);
        if (pds == URS_PDS_8E || pds == URS_PDS_8O)
            put((^d[7:0]) ^ (pds == URS_PDS_8O) ^ bp);
        put(!bs);
        put(1'b1);
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_uart_receive_status.sv
`timescale 1ns/10ps
`default_nettype none
module tb_uart_receive_status
    import urs_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ce = 1'b1;
    logic [URS_ADDR_W-1:0] reg_addr = 2'h0;
    logic [URS_DATA_W-1:0] reg_wdata = 16'h0000;
    wire logic serial_receive_pin;
    wire logic [URS_DATA_W-1:0] reg_rdata;
    int n_errors = 0;
    int n_tests = 0;
    localparam logic [15:0] S_I = 16'h0001 << URS_BIT_IDLE;
    localparam logic [15:0] S_A = 16'h0001 << URS_BIT_AVAIL;
    localparam logic [15:0] S_O = 16'h0001 << URS_BIT_OVR;
    localparam logic [15:0] S_P = 16'h0001 << URS_BIT_PARITY_FAULT_FLAG;
    localparam logic [15:0] S_F = 16'h0001 << URS_BIT_FRAMING_FAULT_FLAG;
    localparam logic [15:0] S_E = 16'h0001 << URS_BIT_ADDR_EN;
    localparam logic [15:0] M_9N = 16'(URS_PDS_9N) << URS_PDS_LSB;
    urs_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
        .serial_receive_pin(serial_receive_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    urs_tx_model #(.BIT_CLKS(4)) tx (.sys_clk(sys_clk), .serial_receive_pin(serial_receive_pin));
    // 100 MHz clock
    initial forever #5 sys_clk = ~sys_clk;
    task automatic conclude();
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Reset values, empty data read, short bit period
    task automatic t_reset();
        rd(URS_OFF_STATUS, S_I);
        rd(URS_OFF_MODE, 16'h0000);
        rd(URS_OFF_BAUD, URS_BAUD_RST);
        rd(URS_OFF_DATA, 16'h0000);
        wr(URS_OFF_BAUD, 16'h0003);
    endtask
    // Clock enable low: write and read not taken, state kept
    task automatic t_freeze();
        ce <= 1'b0;
        wr(URS_OFF_BAUD, 16'h00FF);
        rd(URS_OFF_STATUS, 16'h0000);
        @(posedge sys_clk);
        ce <= 1'b1;
        rd(URS_OFF_BAUD, 16'h0003);
    endtask
    // Busy during start bit, then one character through the queue
    task automatic t_basic();
        fork
            tx.send(9'h0A5, URS_PDS_8N, 1'b0, 1'b0);
            begin
                repeat (2) @(posedge sys_clk);
                rd(URS_OFF_STATUS, 16'h0000);
            end
        join
        rd(URS_OFF_STATUS, S_I | S_A);
        rd(URS_OFF_DATA, 16'h00A5);
        repeat (70) @(posedge sys_clk);
        rd(URS_OFF_STATUS, S_I);
    endtask
    // Good and bad parity in even and odd formats
    task automatic t_parity();
        for (int m = 1; m <= 2; m++)
        begin
            wr(URS_OFF_MODE, 16'(m) << URS_PDS_LSB);
            for (int b = 0; b < 2; b++)
            begin
                tx.send(9'h03C, 2'(m), b[0], 1'b0);
                rd(URS_OFF_STATUS, S_I | S_A | (b[0] ? S_P : 16'h0000));
                rd(URS_OFF_DATA, 16'h003C);
            end
        end
        wr(URS_OFF_MODE, 16'h0000);
        tx.send(9'h05A, URS_PDS_8N, 1'b0, 1'b1);
        rd(URS_OFF_STATUS, S_I | S_A | S_F);
        rd(URS_OFF_DATA, 16'h005A);
        rd(URS_OFF_STATUS, S_I);
    endtask
    // Fill four, no software set, fifth overruns, clear flushes
    task automatic t_overrun();
        for (int i = 1; i <= 4; i++)
            tx.send(9'(i), URS_PDS_8N, 1'b0, 1'b0);
        wr(URS_OFF_STATUS, S_O);
        rd(URS_OFF_STATUS, S_I | S_A);
        tx.send(9'h005, URS_PDS_8N, 1'b0, 1'b0);
        rd(URS_OFF_STATUS, S_I | S_A | S_O);
        rd(URS_OFF_DATA, 16'h0001);
        wr(URS_OFF_STATUS, 16'h0000);
        rd(URS_OFF_STATUS, S_I);
        rd(URS_OFF_DATA, 16'h0000);
    endtask
    // Address detect in 9-bit format, off, and without effect in 8-bit
    task automatic t_addr();
        wr(URS_OFF_MODE, M_9N);
        wr(URS_OFF_STATUS, S_E);
        tx.send(9'h055, URS_PDS_9N, 1'b0, 1'b0);
        tx.send(9'h1A5, URS_PDS_9N, 1'b0, 1'b0);
        rd(URS_OFF_DATA, 16'h01A5);
        rd(URS_OFF_STATUS, S_E | S_I);
        wr(URS_OFF_STATUS, 16'h0000);
        tx.send(9'h055, URS_PDS_9N, 1'b0, 1'b0);
        rd(URS_OFF_DATA, 16'h0055);
        wr(URS_OFF_MODE, 16'h0000);
        wr(URS_OFF_STATUS, S_E);
        tx.send(9'h055, URS_PDS_8N, 1'b0, 1'b0);
        rd(URS_OFF_DATA, 16'h0055);
        wr(URS_OFF_STATUS, 16'h0000);
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_freeze();
        t_basic();
        t_parity();
        t_overrun();
        t_addr();
        conclude();
    end
    // Watchdog
    initial
    begin
        #100us;
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
